// File: amb_pkg.sv
// Constants for the alert mask bank: command, phase, selectors, field positions.
// Assumes the bus engine delivers decoded transactions in the same clock domain.
package amb_pkg;

	localparam int         AMB_CLASSES   = 5;
	localparam int         AMB_IDX_W     = 3;
	localparam logic [7:0] AMB_CMD_MASK  = 8'h1b;
	localparam logic [7:0] AMB_PHASE_ALL = 8'hff;
	localparam logic [7:0] AMB_MASK_RST  = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Status-class selectors
	localparam logic [7:0] AMB_SEL_VOUT  = 8'h7a;
	localparam logic [7:0] AMB_SEL_IOUT  = 8'h7b;
	localparam logic [7:0] AMB_SEL_INPUT = 8'h7c;
	localparam logic [7:0] AMB_SEL_TEMP  = 8'h7d;
	localparam logic [7:0] AMB_SEL_CML   = 8'h7e;

	// Class slots inside the bank
	localparam int AMB_IDX_VOUT  = 0;
	localparam int AMB_IDX_IOUT  = 1;
	localparam int AMB_IDX_INPUT = 2;
	localparam int AMB_IDX_TEMP  = 3;
	localparam int AMB_IDX_CML   = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int AMB_OV_FAULT_MASK_BIT           = 7;
	localparam int AMB_OV_WARN_MASK_BIT            = 6;
	localparam int AMB_UV_WARN_MASK_BIT            = 5;
	localparam int AMB_UV_FAULT_MASK_BIT           = 4;
	localparam int AMB_OUT_RANGE_MASK_BIT          = 3;
	localparam int AMB_TURN_ON_TIMEOUT_MASK_BIT    = 2;
	localparam int AMB_OVERCURRENT_FAULT_MASK_BIT  = 7;
	localparam int AMB_OVERCURRENT_WARN_MASK_BIT   = 5;
	localparam int AMB_UNDERCURRENT_FAULT_MASK_BIT = 4;
	localparam int AMB_LOW_INPUT_MASK_BIT          = 3;
	localparam int AMB_OVERTEMP_FAULT_MASK_BIT     = 7;
	localparam int AMB_OVERTEMP_WARN_MASK_BIT      = 6;
	localparam int AMB_BAD_COMMAND_MASK_BIT        = 7;
	localparam int AMB_BAD_DATA_MASK_BIT           = 6;
	localparam int AMB_CHECKSUM_FAIL_MASK_BIT      = 5;
	localparam int AMB_MEMORY_FAULT_MASK_BIT       = 4;
	localparam int AMB_OTHER_COMM_FAULT_MASK_BIT   = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Writable bit sets per class
	localparam logic [7:0] AMB_WMASK_VOUT = 8'((1 << AMB_OV_FAULT_MASK_BIT) | (1 << AMB_OV_WARN_MASK_BIT)
		| (1 << AMB_UV_WARN_MASK_BIT) | (1 << AMB_UV_FAULT_MASK_BIT)
		| (1 << AMB_OUT_RANGE_MASK_BIT) | (1 << AMB_TURN_ON_TIMEOUT_MASK_BIT));
	localparam logic [7:0] AMB_WMASK_IOUT = 8'((1 << AMB_OVERCURRENT_FAULT_MASK_BIT)
		| (1 << AMB_OVERCURRENT_WARN_MASK_BIT) | (1 << AMB_UNDERCURRENT_FAULT_MASK_BIT));
	localparam logic [7:0] AMB_WMASK_INPUT = 8'(1 << AMB_LOW_INPUT_MASK_BIT);
	localparam logic [7:0] AMB_WMASK_TEMP  = 8'((1 << AMB_OVERTEMP_FAULT_MASK_BIT)
		| (1 << AMB_OVERTEMP_WARN_MASK_BIT));
	localparam logic [7:0] AMB_WMASK_CML = 8'((1 << AMB_BAD_COMMAND_MASK_BIT) | (1 << AMB_BAD_DATA_MASK_BIT)
		| (1 << AMB_CHECKSUM_FAIL_MASK_BIT) | (1 << AMB_MEMORY_FAULT_MASK_BIT)
		| (1 << AMB_OTHER_COMM_FAULT_MASK_BIT));

	localparam logic [7:0] AMB_SEL_TAB [0:AMB_CLASSES-1] = '{AMB_SEL_VOUT, AMB_SEL_IOUT,
		AMB_SEL_INPUT, AMB_SEL_TEMP, AMB_SEL_CML};
	localparam logic [7:0] AMB_WMASK_TAB [0:AMB_CLASSES-1] = '{AMB_WMASK_VOUT, AMB_WMASK_IOUT,
		AMB_WMASK_INPUT, AMB_WMASK_TEMP, AMB_WMASK_CML};

endpackage

// File: amb_rst_sync.sv
// Reset release synchroniser: asserts at once, releases after two clock edges.
// Assumes a free-running clock; it ignores the clock enable so reset always ends.
`timescale 1ns/1ps
module amb_rst_sync (
	input  wire logic clock,
	input  wire logic rst_n,
	output logic      rst_sync_n
);

	logic stage_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage_reg  <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			stage_reg  <= 1'b1;
			rst_sync_n <= stage_reg;
		end
	end

endmodule

// File: amb_mask_byte.sv
// One alert mask class: a byte with a fixed set of writable bits.
// Assumes write and nonvolatile-load strobes are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module amb_mask_byte #(
	parameter logic [7:0] WMASK = 8'hff,
	parameter logic [7:0] RST   = 8'h00
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	input  wire logic       ld_en,
	input  wire logic [7:0] ld_data,
	output logic [7:0]      mask_reg
);

	// A class with no writable bit would be a constant, not a register
	if (WMASK == 8'h00) begin : g_wmask_check
		$error("mask class without writable bits");
	end

	// Host write wins over a store load in the same cycle: it is the newer intent
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= RST & WMASK;
		end else if (clk_en) begin
			if (wr_en) begin
				mask_reg <= wr_data & WMASK;
			end else if (ld_en) begin
				mask_reg <= ld_data & WMASK;
			end
		end
	end

endmodule

// File: amb_alert_mask_bank.sv
// Alert mask bank: per-class mask bytes, the mask command decode and the alert line.
// Assumes the bus engine, status registers and store share this clock; no pin sync needed.
`timescale 1ns/1ps

module amb_alert_mask_bank
	import amb_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic [7:0] phase_sel,
	input  wire logic       req_valid,
	input  wire logic       req_write,
	input  wire logic       req_read,
	input  wire logic [7:0] req_cmd,
	input  wire logic [7:0] req_lo,
	input  wire logic [7:0] req_hi,
	input  wire logic       nvm_ld_valid,
	input  wire logic [7:0] nvm_ld_sel,
	input  wire logic [7:0] nvm_ld_data,
	input  wire logic [7:0] status_vout,
	input  wire logic [7:0] status_iout,
	input  wire logic [7:0] status_input,
	input  wire logic [7:0] status_temp,
	input  wire logic [7:0] status_cml,
	output logic            rsp_valid,
	output logic            rsp_err,
	output logic [7:0]      rsp_data,
	output logic            nvm_wr_valid,
	output logic [7:0]      nvm_wr_sel,
	output logic [7:0]      nvm_wr_data,
	output logic            alert_n
);

	logic                 rst_sync_n;
	logic [7:0]           status_arr [0:AMB_CLASSES-1];
	logic [7:0]           mask_arr   [0:AMB_CLASSES-1];
	logic                 hit;
	logic                 phase_ok;
	logic                 sel_hit;
	logic [AMB_IDX_W-1:0] sel_idx;
	logic                 ld_hit;
	logic [AMB_IDX_W-1:0] ld_idx;
	logic                 req_ok;
	logic                 wr_go;
	logic                 rd_go;
	logic [7:0]           rd_mux;
	logic                 any_open;

	amb_rst_sync u_rst_sync (
		.clock      (clock),
		.rst_n      (rst_n),
		.rst_sync_n (rst_sync_n)
	);

	assign status_arr[AMB_IDX_VOUT]  = status_vout;
	assign status_arr[AMB_IDX_IOUT]  = status_iout;
	assign status_arr[AMB_IDX_INPUT] = status_input;
	assign status_arr[AMB_IDX_TEMP]  = status_temp;
	assign status_arr[AMB_IDX_CML]   = status_cml;

	////////////////////////////////////////////////////////////////////////////////
	// Command decode

	// Slot index must reach every class or selectors would alias
	if ((1 << AMB_IDX_W) < AMB_CLASSES) begin : g_idx_check
		$error("class slot index too narrow");
	end

	always_comb begin
		sel_hit = 1'b0;
		sel_idx = '0;
		ld_hit  = 1'b0;
		ld_idx  = '0;
		for (int i = 0; i < AMB_CLASSES; i++) begin
			if (req_lo == AMB_SEL_TAB[i]) begin
				sel_hit = 1'b1;
				sel_idx = AMB_IDX_W'(i);
			end
			if (nvm_ld_sel == AMB_SEL_TAB[i]) begin
				ld_hit = 1'b1;
				ld_idx = AMB_IDX_W'(i);
			end
		end
	end

	assign hit      = req_valid && (req_cmd == AMB_CMD_MASK);
	assign phase_ok = (phase_sel == AMB_PHASE_ALL);
	assign req_ok   = phase_ok && sel_hit && (req_write ^ req_read);
	// selector low byte, value high byte
	assign wr_go    = hit && req_ok && req_write;
	// selector block in, mask block out
	assign rd_go    = hit && req_ok && req_read;
	assign rd_mux   = mask_arr[sel_idx];

	////////////////////////////////////////////////////////////////////////////////
	// Mask storage

	// Writable sets live in the package so store copy and alert gate agree
	// current writable bits
	for (genvar g = 0; g < AMB_CLASSES; g++) begin : g_class
		amb_mask_byte #(
			.WMASK (AMB_WMASK_TAB[g]),
			.RST   (AMB_MASK_RST)
		) u_mask (
			.clock    (clock),
			.rst_n    (rst_sync_n),
			.clk_en   (clk_en),
			.wr_en    (wr_go && (sel_idx == AMB_IDX_W'(g))),
			.wr_data  (req_hi),
			.ld_en    (nvm_ld_valid && ld_hit && (ld_idx == AMB_IDX_W'(g))),
			.ld_data  (nvm_ld_data),
			.mask_reg (mask_arr[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Answer path

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rsp_valid <= 1'b0;
			rsp_err   <= 1'b0;
			rsp_data  <= 8'h00;
		end else if (clk_en) begin
			rsp_valid <= hit;
			rsp_err   <= hit && !req_ok;
			rsp_data  <= rd_go ? rd_mux : 8'h00;
		end
	end

	// Store copy so the nonvolatile side can back up every accepted write
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			nvm_wr_valid <= 1'b0;
			nvm_wr_sel   <= 8'h00;
			nvm_wr_data  <= 8'h00;
		end else if (clk_en) begin
			nvm_wr_valid <= wr_go;
			if (wr_go) begin
				nvm_wr_sel  <= req_lo;
				nvm_wr_data <= req_hi & AMB_WMASK_TAB[sel_idx];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alert line

	// status bits are only read here, gated by the writable set and the mask
	always_comb begin
		any_open = 1'b0;
		for (int i = 0; i < AMB_CLASSES; i++) begin
			// set mask bit closes the source
			any_open = any_open | (|(status_arr[i] & AMB_WMASK_TAB[i] & ~mask_arr[i]));
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			alert_n <= 1'b1;
		end else if (clk_en) begin
			alert_n <= !any_open;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock iff clk_en);
	endclocking
	default disable iff (!rst_sync_n);

	alert_raise_a: assert property (any_open |=> !alert_n)
		else $error("alert not raised for an unmasked status bit");

	alert_drop_a: assert property (!any_open |=> alert_n)
		else $error("alert raised with every status bit masked or clear");

	vout_write_a: assert property (
		wr_go && (sel_idx == AMB_IDX_W'(AMB_IDX_VOUT))
		|=> mask_arr[AMB_IDX_VOUT] == ($past(req_hi) & AMB_WMASK_VOUT))
		else $error("voltage mask did not take the written byte");

	read_answer_a: assert property (
		rd_go |=> rsp_valid && !rsp_err && (rsp_data == $past(rd_mux)))
		else $error("read answer missing or wrong");

	phase_block_a: assert property (
		hit && !phase_ok && !nvm_ld_valid |=> rsp_valid && rsp_err && !nvm_wr_valid
		&& $stable(mask_arr[AMB_IDX_VOUT]) && $stable(mask_arr[AMB_IDX_CML]))
		else $error("mask access honoured outside all-phases");

	nvm_load_a: assert property (
		nvm_ld_valid && ld_hit && !(wr_go && sel_idx == ld_idx)
		|=> mask_arr[$past(ld_idx)] == ($past(nvm_ld_data) & AMB_WMASK_TAB[$past(ld_idx)]))
		else $error("store load not applied");

	vout_low_a: assert property (mask_arr[AMB_IDX_VOUT][1:0] == 2'b00)
		else $error("voltage mask low bits not zero");

	iout_zero_a: assert property ((mask_arr[AMB_IDX_IOUT] & ~AMB_WMASK_IOUT) == 8'h00)
		else $error("current mask unsupported bit set");

	input_zero_a: assert property ((mask_arr[AMB_IDX_INPUT] & ~AMB_WMASK_INPUT) == 8'h00)
		else $error("input mask unsupported bit set");

	temp_zero_a: assert property (mask_arr[AMB_IDX_TEMP][5:0] == 6'h00)
		else $error("temperature mask low bits not zero");

	cml_zero_a: assert property (
		mask_arr[AMB_IDX_CML][3:2] == 2'b00 && mask_arr[AMB_IDX_CML][0] == 1'b0)
		else $error("comm mask unsupported bit set");

	store_copy_a: assert property (
		wr_go |=> nvm_wr_valid && ((nvm_wr_data & ~AMB_WMASK_TAB[$past(sel_idx)]) == 8'h00))
		else $error("store copy carries unsupported bits");

	foreign_cmd_a: assert property (
		req_valid && (req_cmd != AMB_CMD_MASK) |=> !rsp_valid)
		else $error("answered a foreign command");

	vout_fields_a: assert property (
		wr_go && (sel_idx == AMB_IDX_W'(AMB_IDX_VOUT))
		|=> mask_arr[AMB_IDX_VOUT][7:2] == $past(req_hi[7:2]))
		else $error("voltage mask fields not taken from the write");

	iout_write_a: assert property (
		wr_go && (sel_idx == AMB_IDX_W'(AMB_IDX_IOUT))
		|=> mask_arr[AMB_IDX_IOUT] == {$past(req_hi[7]), 1'b0, $past(req_hi[5:4]), 4'h0})
		else $error("current mask fields wrong after write");

	input_write_a: assert property (
		wr_go && (sel_idx == AMB_IDX_W'(AMB_IDX_INPUT))
		|=> mask_arr[AMB_IDX_INPUT] == {4'h0, $past(req_hi[3]), 3'h0})
		else $error("input mask fields wrong after write");

	temp_write_a: assert property (
		wr_go && (sel_idx == AMB_IDX_W'(AMB_IDX_TEMP))
		|=> mask_arr[AMB_IDX_TEMP] == {$past(req_hi[7:6]), 6'h00})
		else $error("temperature mask fields wrong after write");

	cml_write_a: assert property (
		wr_go && (sel_idx == AMB_IDX_W'(AMB_IDX_CML))
		|=> mask_arr[AMB_IDX_CML] == {$past(req_hi[7:4]), 2'b00, $past(req_hi[1]), 1'b0})
		else $error("comm mask fields wrong after write");

	refused_quiet_a: assert property (
		hit && !req_ok |=> !nvm_wr_valid && (rsp_data == 8'h00))
		else $error("refused access leaked data or a store copy");

	read_idle_a: assert property (!rd_go |=> rsp_data == 8'h00)
		else $error("answer byte not cleared without a read");

	iout_low_a: assert property (
		rd_go && (sel_idx == AMB_IDX_W'(AMB_IDX_IOUT)) |=> rsp_data[2:0] == 3'h0)
		else $error("current mask low bits not read as zero");

	store_sel_a: assert property (wr_go |=> nvm_wr_sel == $past(req_lo))
		else $error("store copy selector wrong");

	write_wins_a: assert property (
		wr_go && nvm_ld_valid && ld_hit && (ld_idx == sel_idx)
		|=> mask_arr[$past(sel_idx)] == ($past(req_hi) & AMB_WMASK_TAB[$past(sel_idx)]))
		else $error("store load beat a host write");

	// Raw clock here: the enabled clocking would skip the frozen cycles
	clk_freeze_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		!clk_en |=> $stable(alert_n) && $stable(rsp_valid) && $stable(nvm_wr_valid)
		&& $stable(mask_arr[AMB_IDX_TEMP]) && $stable(mask_arr[AMB_IDX_CML]))
		else $error("state moved while the clock enable was low");

	write_seen_c: cover property (wr_go ##1 nvm_wr_valid);
	read_seen_c: cover property (rd_go && sel_idx == AMB_IDX_W'(AMB_IDX_CML) ##1 rsp_valid);
	alert_seen_c: cover property (alert_n ##1 !alert_n ##[1:8] alert_n);
	phase_refused_c: cover property (hit && !phase_ok ##1 rsp_err);
	write_load_clash_c: cover property (wr_go && nvm_ld_valid && ld_hit && (ld_idx == sel_idx));

endmodule

// File: amb_host_model.sv
// Bus host model: issues mask-command requests and collects the one-cycle answer.
// Assumes the bank answers at the enabled edge after the request is taken.
`timescale 1ns/1ps
module amb_host_model (
	input  wire logic       clock,
	output logic [7:0]      phase_sel,
	output logic            req_valid,
	output logic            req_write,
	output logic            req_read,
	output logic [7:0]      req_cmd,
	output logic [7:0]      req_lo,
	output logic [7:0]      req_hi,
	input  wire logic       rsp_valid,
	input  wire logic       rsp_err,
	input  wire logic [7:0] rsp_data
);
	initial begin
		phase_sel = 8'hff;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_read  = 1'b0;
		req_cmd   = 8'h00;
		req_lo    = 8'h00;
		req_hi    = 8'h00;
	end

	task automatic set_phase(input logic [7:0] p);
		@(negedge clock);
		phase_sel = p;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// selector low, mask high
	task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] sel,
		input logic [7:0] val, output logic ok, output logic err, output logic [7:0] data);
		@(negedge clock);
		req_valid = 1'b1;
		req_write = wr;
		req_read  = !wr;
		req_cmd   = cmd;
		req_lo    = sel;
		req_hi    = wr ? val : ~sel;
		@(negedge clock);
		ok   = rsp_valid;
		err  = rsp_err;
		data = rsp_data;
		// Valid drops and the selector and value lines flip so a stale value never looks valid
		req_valid = 1'b0;
		req_lo    = ~req_lo;
		req_hi    = ~req_hi;
	endtask
endmodule

// File: test_amb_alert_mask_bank.sv
// Testbench for the alert mask bank: host reads/writes, refusals, store loads, alert.
// Assumes the host model in amb_host_model.sv; all inputs change on falling edges.
`timescale 1ns/1ps
module test_amb_alert_mask_bank;
	import amb_pkg::*;
	logic       clock;
	logic       rst_n;
	logic       clk_en;
	logic [7:0] phase_sel;
	logic       req_valid;
	logic       req_write;
	logic       req_read;
	logic [7:0] req_cmd;
	logic [7:0] req_lo;
	logic [7:0] req_hi;
	logic       nvm_ld_valid;
	logic [7:0] nvm_ld_sel;
	logic [7:0] nvm_ld_data;
	logic [7:0] st;
	logic       rsp_valid;
	logic       rsp_err;
	logic [7:0] rsp_data;
	logic       nvm_wr_valid;
	logic [7:0] nvm_wr_sel;
	logic [7:0] nvm_wr_data;
	logic       alert_n;
	int         err_total;
	int         n_compared;
	int         cycles;
	logic       ok;
	logic       er;
	logic [7:0] d;

	amb_alert_mask_bank i_amb_alert_mask_bank (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.phase_sel(phase_sel), .req_valid(req_valid), .req_write(req_write), .req_read(req_read),
		.req_cmd(req_cmd), .req_lo(req_lo), .req_hi(req_hi), .nvm_ld_valid(nvm_ld_valid),
		.nvm_ld_sel(nvm_ld_sel), .nvm_ld_data(nvm_ld_data), .status_vout(st), .status_iout(st),
		.status_input(st), .status_temp(st), .status_cml(st), .rsp_valid(rsp_valid),
		.rsp_err(rsp_err), .rsp_data(rsp_data), .nvm_wr_valid(nvm_wr_valid),
		.nvm_wr_sel(nvm_wr_sel), .nvm_wr_data(nvm_wr_data), .alert_n(alert_n));
	amb_host_model i_amb_host_model (.clock(clock), .phase_sel(phase_sel), .req_valid(req_valid),
		.req_write(req_write), .req_read(req_read), .req_cmd(req_cmd), .req_lo(req_lo),
		.req_hi(req_hi), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic seen);
		chk_byte(what, {7'h00, exp}, {7'h00, seen});
	endtask

	task automatic wr_mask(input logic [7:0] sel, input logic [7:0] val, input logic e);
		i_amb_host_model.xfer(1'b1, AMB_CMD_MASK, sel, val, ok, er, d);
		chk_bit("write rsp_valid", 1'b1, ok);
		chk_bit("write rsp_err", e, er);
		chk_bit("nvm_wr_valid", !e, nvm_wr_valid);
		if (!e)
			chk_byte("nvm_wr_sel", sel, nvm_wr_sel);
	endtask

	task automatic rd_mask(input logic [7:0] sel, input logic [7:0] exp);
		i_amb_host_model.xfer(1'b0, AMB_CMD_MASK, sel, 8'h00, ok, er, d);
		chk_bit("read rsp_valid", 1'b1, ok);
		chk_bit("read rsp_err", 1'b0, er);
		chk_byte("read mask", exp, d);
	endtask

	task automatic nvm_load(input logic [7:0] sel, input logic [7:0] val);
		@(negedge clock);
		nvm_ld_valid = 1'b1;
		nvm_ld_sel   = sel;
		nvm_ld_data  = val;
		@(negedge clock);
		nvm_ld_valid = 1'b0;
	endtask

	task automatic chk_alert(input logic exp);
		repeat (2) @(negedge clock);
		chk_bit("alert_n", exp, alert_n);
	endtask

	// Hang guard, well above the roughly 135 cycles the tests need
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		nvm_ld_valid = 1'b0;
		nvm_ld_sel = 8'h00;
		nvm_ld_data = 8'h00;
		st = 8'h00;
		err_total = 0;
		n_compared = 0;
		cycles = 0;
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		for (int i = 0; i < AMB_CLASSES; i++)
			rd_mask(AMB_SEL_TAB[i], AMB_MASK_RST);
		for (int i = 0; i < AMB_CLASSES; i++) begin
			wr_mask(AMB_SEL_TAB[i], 8'hff, 1'b0);
			chk_byte("nvm_wr_data", AMB_WMASK_TAB[i], nvm_wr_data);
			rd_mask(AMB_SEL_TAB[i], AMB_WMASK_TAB[i]);
		end
		st = 8'hff;
		chk_alert(1'b1);
		for (int i = 0; i < AMB_CLASSES; i++) begin
			wr_mask(AMB_SEL_TAB[i], 8'h00, 1'b0);
			chk_alert(1'b0);
			wr_mask(AMB_SEL_TAB[i], AMB_WMASK_TAB[i], 1'b0);
			chk_alert(1'b1);
		end
		st = 8'h00;
		wr_mask(AMB_SEL_VOUT, 8'h00, 1'b0);
		chk_alert(1'b1);
		i_amb_host_model.set_phase(8'h00);
		wr_mask(AMB_SEL_IOUT, 8'h00, 1'b1);
		i_amb_host_model.xfer(1'b0, AMB_CMD_MASK, AMB_SEL_IOUT, 8'h00, ok, er, d);
		chk_bit("refused read rsp_err", 1'b1, er);
		chk_byte("refused read data", 8'h00, d);
		i_amb_host_model.set_phase(8'hff);
		rd_mask(AMB_SEL_IOUT, AMB_WMASK_IOUT);
		wr_mask(8'h7f, 8'hff, 1'b1);
		i_amb_host_model.xfer(1'b1, 8'h1c, AMB_SEL_IOUT, 8'h00, ok, er, d);
		chk_bit("other command rsp_valid", 1'b0, ok);
		rd_mask(AMB_SEL_IOUT, AMB_WMASK_IOUT);
		nvm_load(AMB_SEL_TEMP, 8'h3f);
		rd_mask(AMB_SEL_TEMP, 8'h00);
		nvm_load(AMB_SEL_IOUT, 8'h47);
		rd_mask(AMB_SEL_IOUT, 8'h00);
		nvm_load(AMB_SEL_CML, 8'hff);
		rd_mask(AMB_SEL_CML, AMB_WMASK_CML);
		// Frozen clock enable: a store load must not land
		clk_en = 1'b0;
		nvm_load(AMB_SEL_CML, 8'h00);
		clk_en = 1'b1;
		rd_mask(AMB_SEL_CML, AMB_WMASK_CML);
		// Host write and store load to one class in the same cycle
		fork
			wr_mask(AMB_SEL_TEMP, 8'h40, 1'b0);
			nvm_load(AMB_SEL_TEMP, 8'h80);
		join
		rd_mask(AMB_SEL_TEMP, 8'h40);
		give_verdict();
	end
endmodule
